// ==== src/dtcr_defs.vh ====
// Constants for the dual timer with shared capture/reload register.
// Assumes a plain word register port driven by a processor on clk_i.
`ifndef DTCR_DEFS_VH
`define DTCR_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DTCR_OFF_CORE_CTRL 16'hFF48
`define DTCR_OFF_CORE_IRQ 16'hFF68
`define DTCR_OFF_AUX_CTRL 16'hFF4A
`define DTCR_OFF_CORE_CNT 16'hFF50
`define DTCR_OFF_AUX_CNT 16'hFF52
`define DTCR_OFF_SHARED 16'hFF54
`define DTCR_OFF_SHARED_IRQ 16'hFF6A

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DTCR_CC_RELOAD 15
`define DTCR_CC_TOGGLE 10
`define DTCR_CC_OE 9
`define DTCR_XX_DIR 7
`define DTCR_XX_RUN 6
`define DTCR_AC_CAPEN 15
`define DTCR_AC_CLR 14
`define DTCR_AC_EDGE_HI 13
`define DTCR_AC_EDGE_LO 12
`define DTCR_AC_MODE 3
`define DTCR_IC_FLAG 7
`define DTCR_IC_EN 6

// ----------------------------------------
// Writable masks and reset values
// ----------------------------------------
`define DTCR_CC_MASK 16'h87C7
`define DTCR_AC_MASK 16'hF0CF
`define DTCR_CTRL_RESET 16'h0000
`define DTCR_IC_RESET 8'h00
`define DTCR_PRESCALE_BASE 3

`endif

// ==== src/dtcr_timer.v ====
// Core and auxiliary 16-bit timers with a shared capture/reload register.
// Assumes a synchronous register port on clk_i; capture pin is asynchronous.
// Overview of operation
// - Core timer counts system clock divided by 8 to 1024 per select field.
// - Core timer counts only while its run bit 6 is one.
// - Core direction bit 7 selects up when zero, down when one.
// - Core wrap in either direction sets its request flag.
// - Core request reaches the interrupt output only while enable bit 6 set.
// - Toggle latch bit 10 inverts on each wrap; software may write it.
// - Output enable bit 9 routes latch to pin, else pin is port data.
// - Reload enable bit 15 loads shared register into core timer on wrap.
// - Each core wrap is output as a count strobe for capture/compare timers.
// - Toggle latch feeds auxiliary counter trigger regardless of pin enable.
// - Auxiliary timer direction bit 7, run bit 6 in both modes.
// - Auxiliary mode bit 3 chooses timer mode or counter mode.
// - Auxiliary timer mode uses same eight prescaler divisors via bits 2-0.
// - Capture enable bit 15 allows capturing auxiliary value into shared register.
// - Clear bit 14 clears auxiliary timer on selected capture pin edge.
// - Edge select bits 13-12 choose which capture pin edges count.
// - Reserved control bits hold no state and read as zero, except core control bit 8.
// - Interrupt control holds flag b7, enable b6, level b5-2, group b1-0.
// - Both counts are word read/write; control registers reset to zero.
// - Counter mode steps only on wrap-caused latch transitions, not writes.
// - Counter mode select: 1x1 rising, 110 falling, 111 both, else off.
// - Selected capture edge sets shared flag; with capture enabled it also latches value.
// - Reload does not set shared flag; core flag still sets.
`timescale 1ns/10ps
`include "dtcr_defs.vh"

module dtcr_timer (
  input wire clk_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire [15:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [15:0] rdata_o,
  input wire capture_input_pin_i,
  input wire port_data_i,
  output wire toggle_output_pin_o,
  output wire core_irq_o,
  output wire shared_irq_o,
  output wire capture_compare_unit_count_o
);

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  reg [15:0] core_ctrl;
  reg [15:0] aux_ctrl;
  reg [7:0] core_ic;
  reg [7:0] shared_ic;
  reg [15:0] core_cnt;
  reg [15:0] aux_cnt;
  reg [15:0] shared_capture_reload;
  reg [9:0] prescale;
  reg [9:0] prescale_q;
  reg [2:0] cap_sync;
  reg cap_level;

  // Prescaler tick: divisor 2^(select+3); fires when low bits all one
  function tick_for;
    input [2:0] sel;
    input [9:0] cnt;
    input [9:0] cnt_prev;
    reg [3:0] bitpos;
    begin
      bitpos = {1'b0, sel} + 4'd2;
      tick_for = cnt[bitpos] & ~cnt_prev[bitpos];
    end
  endfunction

  function hit;
    input [15:0] a;
    input [15:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  wire wr_core_ctrl = wr_i & hit(addr_i, `DTCR_OFF_CORE_CTRL);
  wire wr_aux_ctrl = wr_i & hit(addr_i, `DTCR_OFF_AUX_CTRL);
  wire wr_core_ic = wr_i & hit(addr_i, `DTCR_OFF_CORE_IRQ);
  wire wr_shared_ic = wr_i & hit(addr_i, `DTCR_OFF_SHARED_IRQ);
  wire wr_core_cnt = wr_i & hit(addr_i, `DTCR_OFF_CORE_CNT);
  wire wr_aux_cnt = wr_i & hit(addr_i, `DTCR_OFF_AUX_CNT);
  wire wr_shared = wr_i & hit(addr_i, `DTCR_OFF_SHARED);

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  // Falling edge of a divider bit gives one tick per full divide period
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      prescale <= 10'h000;
      prescale_q <= 10'h000;
    end else if (ce_i) begin
      prescale <= prescale + 10'h001;
      prescale_q <= prescale;
    end
  end

  wire core_tick = tick_for(core_ctrl[2:0], prescale_q, prescale);
  wire aux_tmr_tick = tick_for(aux_ctrl[2:0], prescale_q, prescale);

  // ----------------------------------------
  // Core timer
  // ----------------------------------------
  wire core_dir = core_ctrl[`DTCR_XX_DIR];
  wire core_step = core_ctrl[`DTCR_XX_RUN] & core_tick;
  wire core_wrap = core_step & (core_dir ? (core_cnt == 16'h0000) : (core_cnt == 16'hFFFF));
  wire toggle = core_ctrl[`DTCR_CC_TOGGLE];
  assign capture_compare_unit_count_o = core_wrap;

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      core_cnt <= 16'h0000;
    end else if (ce_i) begin
      if (wr_core_cnt) begin
        core_cnt <= wdata_i;
      end else if (core_wrap && core_ctrl[`DTCR_CC_RELOAD]) begin
        core_cnt <= shared_capture_reload;
      end else if (core_step) begin
        core_cnt <= core_dir ? core_cnt - 16'h0001 : core_cnt + 16'h0001;
      end
    end
  end

  // Control: reserved bits other than bit 8 never stored; wrap toggle beats a software write
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      core_ctrl <= `DTCR_CTRL_RESET;
    end else if (ce_i) begin
      if (wr_core_ctrl) begin
        core_ctrl <= wdata_i & `DTCR_CC_MASK;
      end
      if (core_wrap) begin
        core_ctrl[`DTCR_CC_TOGGLE] <= ~toggle;
      end
    end
  end

  assign toggle_output_pin_o = core_ctrl[`DTCR_CC_OE] ? toggle : port_data_i;

  // ----------------------------------------
  // Auxiliary timer
  // ----------------------------------------
  // Counter trigger uses the wrap itself, so software writes never step it
  wire [2:0] aux_sel = aux_ctrl[2:0];
  wire tog_rise = core_wrap & ~toggle;
  wire tog_fall = core_wrap & toggle;
  wire aux_cnt_tick = aux_sel[2] & ((aux_sel[0] & tog_rise) | (aux_sel[1] & tog_fall));
  wire aux_in_tick = aux_ctrl[`DTCR_AC_MODE] ? aux_cnt_tick : aux_tmr_tick;
  wire aux_step = aux_ctrl[`DTCR_XX_RUN] & aux_in_tick;
  wire aux_dir = aux_ctrl[`DTCR_XX_DIR];

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      aux_ctrl <= `DTCR_CTRL_RESET;
    end else if (ce_i && wr_aux_ctrl) begin
      aux_ctrl <= wdata_i & `DTCR_AC_MASK;
    end
  end

  // ----------------------------------------
  // Capture input
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      cap_sync <= 3'h0;
      cap_level <= 1'b0;
    end else if (ce_i) begin
      cap_sync <= {cap_sync[1:0], capture_input_pin_i};
      if (cap_sync[1] == cap_sync[2]) begin
        cap_level <= cap_sync[2];
      end
    end
  end

  wire cap_agree = (cap_sync[1] == cap_sync[2]);
  wire cap_rise = cap_agree & cap_sync[2] & ~cap_level;
  wire cap_fall = cap_agree & ~cap_sync[2] & cap_level;
  wire cap_edge = (aux_ctrl[`DTCR_AC_EDGE_LO] & cap_rise) | (aux_ctrl[`DTCR_AC_EDGE_HI] & cap_fall);
  wire cap_do = cap_edge & aux_ctrl[`DTCR_AC_CAPEN];
  wire aux_clr = cap_edge & aux_ctrl[`DTCR_AC_CLR];

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      aux_cnt <= 16'h0000;
    end else if (ce_i) begin
      if (aux_clr) begin
        aux_cnt <= 16'h0000;
      end else if (wr_aux_cnt) begin
        aux_cnt <= wdata_i;
      end else if (aux_step) begin
        aux_cnt <= aux_dir ? aux_cnt - 16'h0001 : aux_cnt + 16'h0001;
      end
    end
  end

  // Capture takes the pre-clear value, so capture and clear may coincide
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      shared_capture_reload <= 16'h0000;
    end else if (ce_i) begin
      if (cap_do) begin
        shared_capture_reload <= aux_cnt;
      end else if (wr_shared) begin
        shared_capture_reload <= wdata_i;
      end
    end
  end

  // ----------------------------------------
  // Interrupt control registers
  // ----------------------------------------
  // Hardware set wins over a software clear in the same cycle
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      core_ic <= `DTCR_IC_RESET;
      shared_ic <= `DTCR_IC_RESET;
    end else if (ce_i) begin
      if (wr_core_ic) begin
        core_ic <= wdata_i[7:0];
      end
      if (core_wrap) begin
        core_ic[`DTCR_IC_FLAG] <= 1'b1;
      end
      if (wr_shared_ic) begin
        shared_ic <= wdata_i[7:0];
      end
      // Only capture-pin edges set this flag; reload never does
      if (cap_edge || aux_clr) begin
        shared_ic[`DTCR_IC_FLAG] <= 1'b1;
      end
    end
  end

  assign core_irq_o = core_ic[`DTCR_IC_FLAG] & core_ic[`DTCR_IC_EN];
  assign shared_irq_o = shared_ic[`DTCR_IC_FLAG] & shared_ic[`DTCR_IC_EN];

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 16'h0000;
    end else if (ce_i) begin
      if (rd_i) begin
        case (addr_i)
          `DTCR_OFF_CORE_CTRL: rdata_o <= core_ctrl;
          `DTCR_OFF_AUX_CTRL: rdata_o <= aux_ctrl;
          `DTCR_OFF_CORE_IRQ: rdata_o <= {8'h00, core_ic};
          `DTCR_OFF_SHARED_IRQ: rdata_o <= {8'h00, shared_ic};
          `DTCR_OFF_CORE_CNT: rdata_o <= core_cnt;
          `DTCR_OFF_AUX_CNT: rdata_o <= aux_cnt;
          `DTCR_OFF_SHARED: rdata_o <= shared_capture_reload;
          default: rdata_o <= 16'h0000;
        endcase
      end else begin
        rdata_o <= 16'h0000;
      end
    end
  end

endmodule // dtcr_timer

// ==== tb/dtcr_timer_chk.sv ====
// Port checker for the dual timer block.
// Assumes ce_i stays high; control writes are shadowed here.
`timescale 1ns/10ps
module dtcr_chk (
  input wire clk_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire [15:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [15:0] rdata_o,
  input wire capture_input_pin_i,
  input wire port_data_i,
  input wire toggle_output_pin_o,
  input wire core_irq_o,
  input wire shared_irq_o,
  input wire capture_compare_unit_count_o
);
  // ----
  // Shadows
  // ----
  reg oe, tgl, ien, sen, pin_d;
  reg [1:0] ci;
  reg [2:0] quiet;
  wire w_ok = wr_i && ce_i;
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      {oe, tgl, ien, sen, ci, pin_d, quiet} <= 10'h000;
    end else begin
      pin_d <= capture_input_pin_i;
      quiet <= (pin_d != capture_input_pin_i) ? 3'h0 : (quiet == 3'h7) ? quiet : quiet + 3'h1;
      // Wrap wins over a same-cycle software write
      if (capture_compare_unit_count_o)
        tgl <= ~tgl;
      else if (w_ok && addr_i == 16'hFF48)
        tgl <= wdata_i[10];
      if (w_ok && addr_i == 16'hFF48)
        oe <= wdata_i[9];
      if (w_ok && addr_i == 16'hFF68)
        ien <= wdata_i[6];
      if (w_ok && addr_i == 16'hFF6A)
        sen <= wdata_i[6];
      if (w_ok && addr_i == 16'hFF4A)
        ci <= wdata_i[13:12];
    end
  end
  property p_rd_idle;
    @(posedge clk_i) disable iff (!rst_n_i) !$past(rd_i) |-> rdata_o == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_pin_port;
    @(posedge clk_i) disable iff (!rst_n_i) !oe |-> toggle_output_pin_o == port_data_i;
  endproperty
  a_pin_port: assert property (p_pin_port) else $error("pin not port data");
  property p_pin_latch;
    @(posedge clk_i) disable iff (!rst_n_i) oe |-> toggle_output_pin_o == tgl;
  endproperty
  a_pin_latch: assert property (p_pin_latch) else $error("pin not toggle latch");
  property p_core_mask;
    @(posedge clk_i) disable iff (!rst_n_i) !ien |-> !core_irq_o;
  endproperty
  a_core_mask: assert property (p_core_mask) else $error("core request while disabled");
  property p_core_set;
    @(posedge clk_i) disable iff (!rst_n_i) capture_compare_unit_count_o && ien && !wr_i |=> core_irq_o;
  endproperty
  a_core_set: assert property (p_core_set) else $error("wrap did not raise core request");
  property p_shared_mask;
    @(posedge clk_i) disable iff (!rst_n_i) !sen |-> !shared_irq_o;
  endproperty
  a_shared_mask: assert property (p_shared_mask) else $error("shared request while disabled");
  property p_no_reload_flag;
    @(posedge clk_i) disable iff (!rst_n_i) sen && quiet == 3'h7 && !shared_irq_o && !wr_i |=> !shared_irq_o;
  endproperty
  a_no_reload_flag: assert property (p_no_reload_flag) else $error("shared flag without edge");
  property p_cap_flag;
    @(posedge clk_i) disable iff (!rst_n_i) sen && ci == 2'b01 && $rose(capture_input_pin_i) |-> ##[1:6] shared_irq_o;
  endproperty
  a_cap_flag: assert property (p_cap_flag) else $error("capture edge missed");
  property p_wrap_space;
    @(posedge clk_i) disable iff (!rst_n_i) capture_compare_unit_count_o |=> !capture_compare_unit_count_o [*7];
  endproperty
  a_wrap_space: assert property (p_wrap_space) else $error("wraps closer than prescale");
endmodule // dtcr_chk
bind dtcr_timer dtcr_chk chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .capture_input_pin_i(capture_input_pin_i),
  .port_data_i(port_data_i), .toggle_output_pin_o(toggle_output_pin_o), .core_irq_o(core_irq_o),
  .shared_irq_o(shared_irq_o), .capture_compare_unit_count_o(capture_compare_unit_count_o));

// ==== tb/test_dual_timer_capture_reload.sv ====
// Self-checking bench for the dual timer block.
// Assumes the register port and offsets of dtcr_timer; ce_i tied high.
`timescale 1ns/10ps
module test_dual_timer_capture_reload;
  localparam [127:0] OFFS = {16'hFF00, 16'hFF6A, 16'hFF54, 16'hFF52, 16'hFF50, 16'hFF4A, 16'hFF68, 16'hFF48};
  reg clk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg [15:0] addr_i = 16'h0000;
  reg [15:0] wdata_i = 16'h0000;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  reg cap_pin = 1'b0;
  reg port_data = 1'b0;
  reg [15:0] d;
  wire [15:0] rdata_o;
  wire pin_o, core_irq, shared_irq, capture_compare_unit;
  integer fail_count = 0;
  integer cmp_count = 0;
  integer cycles = 0;
  integer wraps = 0;
  integer wrap_base = 0;
  integer i;
  always #5 clk_i = ~clk_i;
  dtcr_timer dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .capture_input_pin_i(cap_pin), .port_data_i(port_data),
    .toggle_output_pin_o(pin_o), .core_irq_o(core_irq), .shared_irq_o(shared_irq), .capture_compare_unit_count_o(capture_compare_unit));
  task complete_run;
    begin
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [8*10-1:0] name, input [15:0] seen, input [15:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("[FAIL] %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task wr(input [15:0] a, input [15:0] v);
    begin
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge clk_i);
      wr_i <= 1'b0;
    end
  endtask
  task rd(input [15:0] a);
    begin
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      d = rdata_o;
    end
  endtask
  task rc(input [8*10-1:0] name, input [15:0] a, input [15:0] exp);
    begin
      rd(a);
      chk(name, d, exp);
    end
  endtask
  // Wrap pulse is combinational, so count it away from the edge
  always @(negedge clk_i) begin
    if (capture_compare_unit)
      wraps = wraps + 1;
  end
  always @(posedge clk_i) begin
    cycles = cycles + 1;
    if (cycles == 40000) begin
      fail_count = fail_count + 1;
      complete_run;
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    wr(16'hFF00, 16'hFFFF);
    for (i = 0; i < 8; i = i + 1)
      rc("reset", OFFS[i*16 +: 16], 16'h0000);
    wr(16'hFF48, 16'hFFBF);
    rc("core_ctrl", 16'hFF48, 16'h8787);
    wr(16'hFF4A, 16'hFFBF);
    rc("aux_ctrl", 16'hFF4A, 16'hF08F);
    wr(16'hFF6A, 16'hFFBF);
    rc("irq_ctrl", 16'hFF6A, 16'h00BF);
    wr(16'hFF48, 16'h0000);
    wr(16'hFF4A, 16'h0000);
    wr(16'hFF6A, 16'h0040);
    for (i = 3; i < 6; i = i + 1) begin
      wr(OFFS[i*16 +: 16], 16'hA5C3);
      rc("count", OFFS[i*16 +: 16], 16'hA5C3);
    end
    // Run for 4.5 prescale periods: phase is free, so 4 or 5 steps
    for (i = 0; i < 8; i = i + 1) begin
      wr(16'hFF50, 16'h0000);
      wr(16'hFF48, {13'h0008, i[2:0]});
      repeat ((36 << i) - 4) @(posedge clk_i);
      rc("core_ctrl", 16'hFF48, {13'h0008, i[2:0]});
      wr(16'hFF48, 16'h0000);
      rd(16'hFF50);
      chk("prescale", d == 16'h0004 || d == 16'h0005, 1'b1);
    end
    wr(16'hFF50, 16'h0000);
    wr(16'hFF48, 16'h00C0);
    repeat (32) @(posedge clk_i);
    rc("toggle", 16'hFF48, 16'h04C0);
    wr(16'hFF48, 16'h0000);
    rd(16'hFF50);
    chk("down", d == 16'hFFFB || d == 16'hFFFC, 1'b1);
    rc("core_flag", 16'hFF68, 16'h0080);
    chk("irq_mask", core_irq, 1'b0);
    wr(16'hFF68, 16'h00C0);
    @(negedge clk_i);
    chk("irq_on", core_irq, 1'b1);
    @(posedge clk_i);
    port_data <= 1'b1;
    wr(16'hFF54, 16'hFFFE);
    wr(16'hFF50, 16'hFFFE);
    wr(16'hFF52, 16'h0000);
    wr(16'hFF4A, 16'h004F);
    wrap_base = wraps;
    wr(16'hFF48, 16'h8240);
    repeat (200) @(posedge clk_i);
    wr(16'hFF48, 16'h0400);
    @(negedge clk_i);
    chk("pin_port", pin_o, 1'b1);
    rd(16'hFF52);
    chk("aux_steps", d, wraps - wrap_base);
    chk("wrapped", (wraps - wrap_base) >= 11, 1'b1);
    rd(16'hFF50);
    chk("reload", d == 16'hFFFE || d == 16'hFFFF, 1'b1);
    rc("no_cap", 16'hFF6A, 16'h0040);
    wr(16'hFF52, 16'h0000);
    wr(16'hFF4A, 16'hD040);
    repeat (100) @(posedge clk_i);
    cap_pin <= 1'b1;
    repeat (10) @(negedge clk_i);
    chk("cap_flag", shared_irq, 1'b1);
    rd(16'hFF54);
    chk("captured", d >= 16'h000A && d <= 16'h0010, 1'b1);
    rd(16'hFF52);
    chk("cleared", d < 16'h0003, 1'b1);
    wr(16'hFF6A, 16'h0040);
    @(posedge clk_i);
    cap_pin <= 1'b0;
    repeat (10) @(negedge clk_i);
    chk("fall_off", shared_irq, 1'b0);
    complete_run;
  end
endmodule // test_dual_timer_capture_reload
